// [src/pfa_regs.sv]
// preview frame address registers and per-frame line sequencer
// assumes one clock, synchronous reset, frame and line strobes from same-clock logic
module pfa_regs (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output      logic [31:0] reg_rdata_o,
    // frame timing from the datapath
    input  wire logic        frame_start_i,
    input  wire logic        line_done_i,
    input  wire logic [15:0] write_pitch_i,
    // engine status
    output      logic        busy_o,
    output      logic        sdram_source_o,
    // line requests
    output      logic        line_req_o,
    output      logic        sdram_fetch_o,
    output      logic [13:0] line_num_o,
    output      logic [31:0] rd_addr_o,
    output      logic [31:0] dk_addr_o,
    output      logic [31:0] wr_addr_o
);

    typedef struct packed {
        pfa_pkg::pfa_state_type state;
        logic                   enable;
        logic                   source;
        logic                   oneshot;
        logic                   run_sdram;
        logic                   run_oneshot;
        logic [13:0]            first_line_field;
        logic [13:0]            last_line_field;
        logic [31:0]            read_base_field;
        logic [15:0]            rd_pitch;
        logic [31:0]            dark_base_field;
        logic [15:0]            dk_pitch;
        logic [31:0]            wr_base;
        logic [13:0]            cur_first;
        logic [13:0]            cur_last;
        logic [13:0]            line;
        logic [31:0]            rdata;
    } pfa_regs_type;

    pfa_regs_type r_reg;
    pfa_regs_type r_next;

    pfa_line_if lnk ();

    logic start_frame;
    logic last_line;
    logic wr_ctrl;
    logic new_enable;

    pfa_line_addr u_line_addr (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .lnk       (lnk.gen)
    );

    // a frame starts from sdram at once, from the video port on its frame strobe
    always_comb
    begin
        start_frame = 1'b0;
        if ((r_reg.state == pfa_pkg::PFA_IDLE) && r_reg.enable)
        begin
            start_frame = r_reg.run_sdram || frame_start_i;
        end
    end

    // a window whose end lies before its start closes after one line
    assign last_line = (r_reg.line >= r_reg.cur_last);

    assign wr_ctrl    = reg_wr_i && (reg_addr_i == pfa_pkg::OFF_CTRL);
    assign new_enable = reg_wdata_i[pfa_pkg::CTRL_ENABLE_BIT];

    always_comb
    begin
        r_next = r_reg;

        // sequencer
        unique case (r_reg.state)
            pfa_pkg::PFA_IDLE:
            begin
                if (start_frame)
                begin
                    // in-use copies are taken only here
                    r_next.cur_first = r_reg.first_line_field;
                    r_next.cur_last  = r_reg.last_line_field;
                    r_next.line      = r_reg.first_line_field;
                    r_next.state     = pfa_pkg::PFA_LINE;
                end
            end
            pfa_pkg::PFA_LINE:
            begin
                if (line_done_i)
                begin
                    if (last_line)
                    begin
                        r_next.state = pfa_pkg::PFA_IDLE;
                        if (r_reg.run_oneshot)
                        begin
                            r_next.enable = 1'b0;
                        end
                    end
                    else
                    begin
                        r_next.line = r_reg.line + 14'h0001;
                    end
                end
            end
        endcase

        // register writes; a write to enable in the same cycle overrides
        // the one-shot auto clear, so software is never lost
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                pfa_pkg::OFF_CTRL:
                begin
                    r_next.enable = new_enable;
                    if (new_enable)
                    begin
                        // mode bits are consumed by the enable and read back as 0
                        r_next.run_sdram   = reg_wdata_i[pfa_pkg::CTRL_SOURCE_BIT]
                                             || r_reg.source;
                        r_next.run_oneshot = reg_wdata_i[pfa_pkg::CTRL_ONESHOT_BIT]
                                             || r_reg.oneshot;
                        r_next.source      = 1'b0;
                        r_next.oneshot     = 1'b0;
                    end
                    else
                    begin
                        r_next.source  = reg_wdata_i[pfa_pkg::CTRL_SOURCE_BIT];
                        r_next.oneshot = reg_wdata_i[pfa_pkg::CTRL_ONESHOT_BIT];
                    end
                end
                pfa_pkg::OFF_VWIN:
                begin
                    r_next.first_line_field =
                        reg_wdata_i[pfa_pkg::VWIN_FIRST_LSB +: pfa_pkg::LINE_W];
                    r_next.last_line_field =
                        reg_wdata_i[pfa_pkg::VWIN_LAST_LSB +: pfa_pkg::LINE_W];
                end
                pfa_pkg::OFF_RD_BASE:
                begin
                    // stored whole even while busy
                    r_next.read_base_field = reg_wdata_i;
                end
                pfa_pkg::OFF_RD_PITCH:
                begin
                    r_next.rd_pitch = reg_wdata_i[15:0];
                end
                pfa_pkg::OFF_DK_BASE:
                begin
                    r_next.dark_base_field = reg_wdata_i;
                end
                pfa_pkg::OFF_DK_PITCH:
                begin
                    r_next.dk_pitch = reg_wdata_i[15:0];
                end
                pfa_pkg::OFF_WR_BASE:
                begin
                    r_next.wr_base = reg_wdata_i;
                end
                default:
                begin
                    r_next.rdata = r_reg.rdata;
                end
            endcase
        end

        // read data stand for the one cycle after the strobe only
        r_next.rdata = pfa_pkg::RDATA_RST;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                pfa_pkg::OFF_CTRL:
                begin
                    r_next.rdata[pfa_pkg::CTRL_ENABLE_BIT]  = r_reg.enable;
                    r_next.rdata[pfa_pkg::CTRL_BUSY_BIT]    =
                        (r_reg.state != pfa_pkg::PFA_IDLE);
                    r_next.rdata[pfa_pkg::CTRL_SOURCE_BIT]  = r_reg.source;
                    r_next.rdata[pfa_pkg::CTRL_ONESHOT_BIT] = r_reg.oneshot;
                end
                pfa_pkg::OFF_VWIN:
                begin
                    r_next.rdata[pfa_pkg::VWIN_FIRST_LSB +: pfa_pkg::LINE_W] =
                        r_reg.first_line_field;
                    r_next.rdata[pfa_pkg::VWIN_LAST_LSB +: pfa_pkg::LINE_W] =
                        r_reg.last_line_field;
                end
                pfa_pkg::OFF_RD_BASE:
                begin
                    // written value, not the in-use copy
                    r_next.rdata = r_reg.read_base_field;
                end
                pfa_pkg::OFF_RD_PITCH:
                begin
                    r_next.rdata[15:0] = r_reg.rd_pitch;
                end
                pfa_pkg::OFF_DK_BASE:
                begin
                    r_next.rdata = r_reg.dark_base_field;
                end
                pfa_pkg::OFF_DK_PITCH:
                begin
                    r_next.rdata[15:0] = r_reg.dk_pitch;
                end
                pfa_pkg::OFF_WR_BASE:
                begin
                    r_next.rdata = r_reg.wr_base;
                end
                default:
                begin
                    r_next.rdata = pfa_pkg::RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            r_reg.state            <= pfa_pkg::PFA_IDLE;
            r_reg.enable           <= 1'b0;
            r_reg.source           <= 1'b0;
            r_reg.oneshot          <= 1'b0;
            r_reg.run_sdram        <= 1'b0;
            r_reg.run_oneshot      <= 1'b0;
            r_reg.first_line_field <= pfa_pkg::LINE_RST;
            r_reg.last_line_field  <= pfa_pkg::LINE_RST;
            r_reg.read_base_field  <= pfa_pkg::BASE_RST;
            r_reg.rd_pitch         <= pfa_pkg::PITCH_RST;
            r_reg.dark_base_field  <= pfa_pkg::BASE_RST;
            r_reg.dk_pitch         <= pfa_pkg::PITCH_RST;
            r_reg.wr_base          <= pfa_pkg::BASE_RST;
            r_reg.cur_first        <= pfa_pkg::LINE_RST;
            r_reg.cur_last         <= pfa_pkg::LINE_RST;
            r_reg.line             <= pfa_pkg::LINE_RST;
            r_reg.rdata            <= pfa_pkg::RDATA_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // address generators latch bases at frame start and step per line
    assign lnk.load = start_frame;
    assign lnk.step = (r_reg.state == pfa_pkg::PFA_LINE) && line_done_i
                      && !last_line;

    assign lnk.base[pfa_pkg::STR_RD]  = r_reg.read_base_field;
    assign lnk.base[pfa_pkg::STR_DK]  = r_reg.dark_base_field;
    assign lnk.base[pfa_pkg::STR_WR]  = r_reg.wr_base;
    assign lnk.pitch[pfa_pkg::STR_RD] = r_reg.rd_pitch;
    assign lnk.pitch[pfa_pkg::STR_DK] = r_reg.dk_pitch;
    // output line step lives in a register outside this bank
    assign lnk.pitch[pfa_pkg::STR_WR] = write_pitch_i;

    // outputs
    assign reg_rdata_o    = r_reg.rdata;
    assign busy_o         = (r_reg.state != pfa_pkg::PFA_IDLE);
    assign sdram_source_o = r_reg.run_sdram;
    assign line_req_o     = (r_reg.state == pfa_pkg::PFA_LINE);
    // read base only drives fetches when the source is sdram
    assign sdram_fetch_o  = (r_reg.state == pfa_pkg::PFA_LINE) && r_reg.run_sdram;
    assign line_num_o     = r_reg.line;
    assign rd_addr_o      = lnk.addr[pfa_pkg::STR_RD];
    assign dk_addr_o      = lnk.addr[pfa_pkg::STR_DK];
    assign wr_addr_o      = lnk.addr[pfa_pkg::STR_WR];

endmodule

// [src/pfa_pkg.sv]
// preview frame address registers: shared constants, offsets and types
// assumes a single 100 MHz clock with a synchronous active-high reset
//
// Overview of operation
// - 32-bit frame read base register sets where input frames are fetched
// - 32-bit dark frame base register sets where dark frames are fetched
// - 32-bit output base register sets where processed frames are stored
// - 16-bit line pitch registers give step between lines, read and dark
// - low five bits of bases and pitches are used as zero, 32-byte aligned
// - writes accepted while busy; new window, base and pitch values apply from next frame start
// - window, base and pitch reads return the latest written value, not the one in use
// - busy status reads 1 while a frame is processed, 0 when idle
// - source bit: 0 video port, 1 sdram fetch; read base used only for sdram
package pfa_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_VWIN     = 8'h04;
    localparam logic [7:0] OFF_RD_BASE  = 8'h08;
    localparam logic [7:0] OFF_RD_PITCH = 8'h0c;
    localparam logic [7:0] OFF_DK_BASE  = 8'h10;
    localparam logic [7:0] OFF_DK_PITCH = 8'h14;
    localparam logic [7:0] OFF_WR_BASE  = 8'h18;

    // control register bit positions
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_BUSY_BIT    = 1;
    localparam int CTRL_SOURCE_BIT  = 2;
    localparam int CTRL_ONESHOT_BIT = 3;

    // field layout
    localparam int VWIN_FIRST_LSB = 16;
    localparam int VWIN_LAST_LSB  = 0;
    localparam int LINE_W         = 14;
    localparam int PITCH_W        = 16;
    localparam int ADDR_W         = 32;
    localparam int ALIGN_BITS     = 5;

    // stream indices
    localparam int STR_RD  = 0;
    localparam int STR_DK  = 1;
    localparam int STR_WR  = 2;
    localparam int NUM_STR = 3;

    // values after reset
    localparam logic [31:0] BASE_RST  = 32'h0000_0000;
    localparam logic [15:0] PITCH_RST = 16'h0000;
    localparam logic [13:0] LINE_RST  = 14'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        PFA_IDLE,
        PFA_LINE
    } pfa_state_type;

endpackage

// [src/pfa_line_if.sv]
// preview frame address: link between the sequencer and the address generators
// assumes both ends sit on the same clock
interface pfa_line_if;
    logic                                            load;
    logic                                            step;
    logic [pfa_pkg::NUM_STR-1:0][pfa_pkg::ADDR_W-1:0]  base;
    logic [pfa_pkg::NUM_STR-1:0][pfa_pkg::PITCH_W-1:0] pitch;
    logic [pfa_pkg::NUM_STR-1:0][pfa_pkg::ADDR_W-1:0]  addr;

    modport ctrl (
        output load,
        output step,
        output base,
        output pitch,
        input  addr
    );

    modport gen (
        input  load,
        input  step,
        input  base,
        input  pitch,
        output addr
    );
endinterface

// [src/pfa_line_addr.sv]
// preview frame address: per-stream line address accumulators
// assumes load and step are never high together
module pfa_line_addr (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // sequencer link
    pfa_line_if.gen   lnk
);

    typedef struct packed {
        logic [pfa_pkg::NUM_STR-1:0][pfa_pkg::ADDR_W-1:0]  addr;
        logic [pfa_pkg::NUM_STR-1:0][pfa_pkg::PITCH_W-1:0] pitch;
    } pfa_gen_type;

    pfa_gen_type r_reg;
    pfa_gen_type r_next;

    always_comb
    begin
        r_next = r_reg;
        for (int i = 0; i < pfa_pkg::NUM_STR; i++)
        begin
            if (lnk.load)
            begin
                // base forced to 32-byte alignment
                r_next.addr[i] = {lnk.base[i][31:pfa_pkg::ALIGN_BITS],
                                  5'h00};
                // pitch held for the whole frame so mid-frame writes wait
                r_next.pitch[i] = lnk.pitch[i];
            end
            else if (lnk.step)
            begin
                // add one aligned pitch per line
                r_next.addr[i] = r_reg.addr[i]
                    + {16'h0000, r_reg.pitch[i][15:pfa_pkg::ALIGN_BITS], 5'h00};
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < pfa_pkg::NUM_STR; i++)
            begin
                r_reg.addr[i]  <= pfa_pkg::BASE_RST;
                r_reg.pitch[i] <= pfa_pkg::PITCH_RST;
            end
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign lnk.addr = r_reg.addr;

endmodule

// [sim/pfa_regs_chk.sv]
// port-level checker for the frame address register block
// assumes one clock and a synchronous active-high reset; bound at file foot
module pfa_regs_chk (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    // register port
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // frame link
    input wire logic        line_done_i,
    input wire logic [15:0] write_pitch_i,
    input wire logic        busy_o,
    input wire logic        sdram_source_o,
    input wire logic        line_req_o,
    input wire logic        sdram_fetch_o,
    input wire logic [13:0] line_num_o,
    input wire logic [31:0] rd_addr_o,
    input wire logic [31:0] dk_addr_o,
    input wire logic [31:0] wr_addr_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_rdata_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_aligned;
        (rd_addr_o[4:0] | dk_addr_o[4:0] | wr_addr_o[4:0]) == 5'h0;
    endproperty
    a_aligned: assert property (p_aligned) else $error("line address not aligned");
    // write pitch is held steady by the bench, so the last sample stands in for the latch
    property p_step;
        (line_req_o && line_done_i) ##1 busy_o |-> line_num_o == $past(line_num_o) + 14'h1
            && wr_addr_o == $past(wr_addr_o) + {16'h0, $past(write_pitch_i) & 16'hffe0};
    endproperty
    a_step: assert property (p_step) else $error("line step wrong");
    property p_hold;
        line_req_o && !line_done_i |=> line_req_o && busy_o && $stable(line_num_o)
            && $stable(rd_addr_o) && $stable(dk_addr_o);
    endproperty
    a_hold: assert property (p_hold) else $error("line request moved early");
    property p_fetch;
        sdram_fetch_o == (line_req_o && sdram_source_o);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not tied to source");
    property p_req_busy;
        line_req_o |-> busy_o;
    endproperty
    a_req_busy: assert property (p_req_busy) else $error("request while idle");
    property p_reset;
        $fell(rst_i) |-> !busy_o && !line_req_o && reg_rdata_o == 32'h0 && rd_addr_o == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not clear after reset");
    property p_readback;
        (reg_wr_i && (reg_addr_i == 8'h08 || reg_addr_i == 8'h10 || reg_addr_i == 8'h18))
            ##1 (reg_rd_i && reg_addr_i == $past(reg_addr_i)) |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("base read back wrong");
    property p_pitch_rsv;
        reg_rd_i && (reg_addr_i == 8'h0c || reg_addr_i == 8'h14) |=> reg_rdata_o[31:16] == 16'h0;
    endproperty
    a_pitch_rsv: assert property (p_pitch_rsv) else $error("pitch upper half not 0");

    c_sdram: cover property ($rose(busy_o) && sdram_source_o);
    c_video: cover property ($rose(busy_o) && !sdram_source_o);
    c_slow:  cover property (line_req_o && !line_done_i ##1 line_done_i);
endmodule

bind pfa_regs pfa_regs_chk i_chk (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .line_done_i, .write_pitch_i, .busy_o, .sdram_source_o,
    .line_req_o, .sdram_fetch_o, .line_num_o, .rd_addr_o, .dk_addr_o, .wr_addr_o);

// [sim/pfa_sdram_model.sv]
// far-side model: datapath and sdram answering line requests, logging addresses
// assumes the latency input changes only between frames
module pfa_sdram_model (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // line requests
    input  wire logic        line_req_i,
    input  wire logic        fetch_i,
    input  wire logic [31:0] rd_addr_i,
    input  wire logic [31:0] dk_addr_i,
    input  wire logic [31:0] wr_addr_i,
    input  wire logic [3:0]  lat_i,
    // answer
    output      logic        line_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0]  cnt;
    logic [31:0] rd_q[$];
    logic [31:0] dk_q[$];
    logic [31:0] wr_q[$];
    logic        fetch_q[$];

    // a zero latency finishes a line in its first cycle, the harshest case
    assign line_done_o = line_req_i && (cnt == lat_i);

    always @(posedge sys_clk_i)
    begin
        if (rst_i || !line_req_i || line_done_o)
            cnt <= 4'h0;
        else
            cnt <= cnt + 4'h1;
        if (!rst_i && line_done_o)
        begin
            rd_q.push_back(rd_addr_i);
            dk_q.push_back(dk_addr_i);
            wr_q.push_back(wr_addr_i);
            fetch_q.push_back(fetch_i);
        end
    end
endmodule

// [sim/pfa_regs_tb.sv]
// self-checking bench for the frame address register block
// assumes the far-side model and the bound checker are compiled alongside
module pfa_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct { logic [7:0] a; logic [31:0] w; logic [31:0] e; } pfa_row_type;
    logic        sys_clk_i, rst_i, reg_wr_i, reg_rd_i, frame_start_i, line_done_i;
    logic        busy_o, sdram_source_o, line_req_o, sdram_fetch_o;
    logic [7:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rd_addr_o, dk_addr_o, wr_addr_o;
    logic [15:0] write_pitch_i;
    logic [13:0] line_num_o;
    logic [3:0]  lat;
    int          num_errors, comparisons, k;
    pfa_row_type rows [8] = '{'{8'h08, 32'h1234_567f, 32'h1234_567f},
        '{8'h0c, 32'hffff_1234, 32'h0000_1234}, '{8'h10, 32'habcd_ef1f, 32'habcd_ef1f},
        '{8'h14, 32'h5555_0047, 32'h0000_0047}, '{8'h18, 32'h8000_0021, 32'h8000_0021},
        '{8'h04, 32'hffff_ffff, 32'h3fff_3fff}, '{8'h1c, 32'hffff_ffff, 32'h0},
        '{8'h04, 32'h0002_0004, 32'h0002_0004}};

    pfa_regs i_dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .frame_start_i, .line_done_i, .write_pitch_i, .busy_o, .sdram_source_o,
        .line_req_o, .sdram_fetch_o, .line_num_o, .rd_addr_o, .dk_addr_o, .wr_addr_o);
    pfa_sdram_model i_mem (.sys_clk_i, .rst_i, .line_req_i(line_req_o), .fetch_i(sdram_fetch_o),
        .rd_addr_i(rd_addr_o), .dk_addr_i(dk_addr_o), .wr_addr_i(wr_addr_o), .lat_i(lat),
        .line_done_o(line_done_i));

    task finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check32(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        // strobe left up so back-to-back writes never drive it twice in one step
        @(posedge sys_clk_i);
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        reg_wr_i <= 1'b0;
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        check32(n, e, reg_rdata_o);
        @(posedge sys_clk_i);
    endtask
    task wait_idle;
        int i;
        i = 0;
        @(negedge sys_clk_i);
        while (busy_o !== 1'b0 && i < 400)
        begin
            @(negedge sys_clk_i);
            i++;
        end
        if (i >= 400)
        begin
            num_errors++;
            $display("wrong value busy_o expected 0 seen %b", busy_o);
            finish_test();
        end
        @(posedge sys_clk_i);
    endtask
    // lines 2 to 4 give three entries; dark and write streams keep their setup
    task check_frame(input logic [31:0] rb, input logic [31:0] rp, input logic f);
        int n;
        check32("line count", 32'h3, 32'(i_mem.rd_q.size()));
        for (n = 0; n < 3; n++)
        begin
            check32("rd_addr_o", rb + 32'(n) * rp, i_mem.rd_q[n]);
            check32("dk_addr_o", 32'habcd_ef00 + 32'(n) * 32'h40, i_mem.dk_q[n]);
            check32("wr_addr_o", 32'h8000_0020 + 32'(n) * 32'h80, i_mem.wr_q[n]);
            check32("sdram_fetch_o", {31'h0, f}, {31'h0, i_mem.fetch_q[n]});
        end
        i_mem.rd_q.delete();
        i_mem.dk_q.delete();
        i_mem.wr_q.delete();
        i_mem.fetch_q.delete();
    endtask

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial
    begin
        {rst_i, reg_wr_i, reg_rd_i, frame_start_i} = 4'h8;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        write_pitch_i = 16'h0085;
        lat = 4'h4;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 8; k++)
            rdchk("reset value", rows[k].a, 32'h0);
        rdchk("ctrl reset", 8'h00, 32'h0);
        for (k = 0; k < 8; k++)
        begin
            wr(rows[k].a, rows[k].w);
            rdchk("reg_rdata_o", rows[k].a, rows[k].e);
        end
        // sdram one-shot frame with a slow far side; rewrites land mid-frame
        wr(8'h00, 32'h0000_000d);
        wr(8'h08, 32'h5000_0000);
        wr(8'h0c, 32'h0000_0200);
        rdchk("read base mid-frame", 8'h08, 32'h5000_0000);
        rdchk("ctrl busy", 8'h00, 32'h0000_0003);
        wait_idle();
        check_frame(32'h1234_5660, 32'h0000_1220, 1'b1);
        rdchk("ctrl after one-shot", 8'h00, 32'h0);
        // video port one-shot: nothing starts until the frame start pulse
        lat <= 4'h0;
        wr(8'h00, 32'h0000_0009);
        reg_wr_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        check32("busy_o before start", 32'h0, {31'h0, busy_o});
        frame_start_i <= 1'b1;
        @(posedge sys_clk_i);
        frame_start_i <= 1'b0;
        wait_idle();
        check_frame(32'h5000_0000, 32'h0000_0200, 1'b0);
        // second reset, with the engine idle after the frame, clears the stored bases
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdchk("base after reset", 8'h08, 32'h0);
        finish_test();
    end
endmodule
